// ### design/fepc_regs.svh
// constants for the fast ethernet phy coding path
// Overview of operation
// - tx path: nibble, 4b5b, scramble, nrzi, mlt3
// - code bit stream runs at 125 MHz
// - rx path reverses tx chain in order
// - rx decodes nrzi transitions, one sample per clock
// - scrambler is an 11-bit lfsr
// - 2047-bit sequence, same at receiver
// - all internal rates from 25 MHz reference
// - fx mode bypasses scrambler and mlt3
// - fx mode skips autoneg and crossover
// - signal detect selects tx, fx-fault, fx-ok
// - fault sends 84 ones then zero in idle
// - received fault pattern forces link down
// - received fault leaves transmitter unchanged
// - fault feature enabled at reset, disableable
// - per-port power down from either register
// - full chip power down stops the coding path, not the register port
// - crossover follows remote pair usage
// - crossover disable sets pair assignment from force-mdix bit
// - mdi tx on 1/2, mdi-x swaps
// - manchester split after squelch qualifies
// - 10base-t rx clock runs while idle
`ifndef FEPC_REGS_SVH
`define FEPC_REGS_SVH
`define FEPC_ADDR_CTRL 4'h0
`define FEPC_ADDR_STAT 4'h1
`define FEPC_CTRL_PORT_PD 0
`define FEPC_CTRL_MII_PD 1
`define FEPC_CTRL_CHIP_PD 2
`define FEPC_CTRL_FEF_DIS 3
`define FEPC_CTRL_XO_DIS 4
`define FEPC_CTRL_FORCE_MDIX 5
`define FEPC_CTRL_RESET 8'h00
`define FEPC_LFSR_SEED 11'h7FF
`define FEPC_FEF_ONES 7'h54
`define FEPC_LOCK_IDLES 6'h3C
`define FEPC_XO_PERIOD 8'hC8
`define FEPC_SYM_IDLE 5'h1F
`define FEPC_SYM_J 5'h18
`define FEPC_SYM_K 5'h11
`define FEPC_SYM_T 5'h0D
`define FEPC_SYM_R 5'h07
`define FEPC_REF_MHZ 25
`define FEPC_BIT_MHZ 125
`define FEPC_BITS_PER_CLK (`FEPC_BIT_MHZ / `FEPC_REF_MHZ)
`endif

// ### design/fepc_pkg.sv
// types for the fast ethernet phy coding path
`default_nettype none
package fepc_pkg;
	typedef enum logic [1:0] {FEPC_SD_TX, FEPC_SD_FX_FAULT, FEPC_SD_FX_OK} fepc_sd_t;
	typedef enum logic [2:0] {FEPC_TX_IDLE, FEPC_TX_J, FEPC_TX_K, FEPC_TX_DATA, FEPC_TX_T,
		FEPC_TX_R} fepc_tx_state_t;
endpackage : fepc_pkg
`default_nettype wire

// ### design/fepc_scrambler.sv
// 11-bit additive scrambler lane, one instance per direction
`default_nettype none
`include "fepc_regs.svh"
module fepc_scrambler (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic adv,
	input wire logic load,
	input wire logic [10:0] load_val,
	input wire logic bypass,
	input wire logic din,
	output logic dout,
	output logic [10:0] state
);
	logic [10:0] lfsr;
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			lfsr <= `FEPC_LFSR_SEED;
		else if (load)
			lfsr <= load_val;
		else if (adv)
			lfsr <= {lfsr[9:0], lfsr[10] ^ lfsr[8]};
	end
	assign dout = bypass ? din : (din ^ lfsr[10] ^ lfsr[8]);
	assign state = lfsr;
endmodule : fepc_scrambler
`default_nettype wire

// ### design/fepc_core.sv
// coding path of one 10/100 phy port: 4b5b, scrambling, nrzi, mlt3, fx fault
//
// The implementer's own choices: the strobed register port and the register offsets.
`default_nettype none
`include "fepc_regs.svh"
module fepc_core (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] mii_txd,
	input wire logic mii_tx_en,
	output logic mii_tx_ready,
	output logic [3:0] mii_rxd,
	output logic mii_rx_dv,
	output logic mii_rx_clk10,
	input wire logic [1:0] fiber_signal_detect_in,
	input wire logic [1:0] line_rx_mlt3,
	input wire logic line_rx_active,
	input wire logic squelch_ok,
	input wire logic manch_in,
	input wire logic remote_on_pins12,
	output logic [1:0] line_tx_mlt3,
	output logic line_tx_nrzi,
	output logic pins12_is_tx,
	output logic link_up,
	output logic far_end_fault,
	output logic port_powered
);
	// control bits, status word
	logic [7:0] ctrl;
	logic fef_en;
	logic pd;
	assign fef_en = !ctrl[`FEPC_CTRL_FEF_DIS];
	assign pd = ctrl[`FEPC_CTRL_PORT_PD] | ctrl[`FEPC_CTRL_MII_PD]
		| ctrl[`FEPC_CTRL_CHIP_PD];
	assign port_powered = !pd;

	fepc_pkg::fepc_sd_t sd_mode;
	always_comb begin
		case (fiber_signal_detect_in)
			2'b00: sd_mode = fepc_pkg::FEPC_SD_TX;
			2'b01: sd_mode = fepc_pkg::FEPC_SD_FX_FAULT;
			default: sd_mode = fepc_pkg::FEPC_SD_FX_OK;
		endcase
	end
	logic fx;
	assign fx = sd_mode != fepc_pkg::FEPC_SD_TX;
	logic fef_local;
	assign fef_local = fef_en && sd_mode == fepc_pkg::FEPC_SD_FX_FAULT;

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			ctrl <= `FEPC_CTRL_RESET;
		else if (reg_wr && reg_addr == `FEPC_ADDR_CTRL)
			ctrl <= reg_wdata;
	end

	logic rx_locked;
	logic fef_rx;
	logic mdix;
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd && reg_addr == `FEPC_ADDR_CTRL)
			reg_rdata <= ctrl;
		else if (reg_rd && reg_addr == `FEPC_ADDR_STAT)
			reg_rdata <= {2'h0, mdix, fx, fef_rx, fef_local, rx_locked, link_up};
		else
			reg_rdata <= 8'h00;
	end

	// transmit: 4b5b encoder
	function automatic logic [4:0] enc4b5b(input logic [3:0] n);
		case (n)
			4'h0: enc4b5b = 5'h1E;
			4'h1: enc4b5b = 5'h09;
			4'h2: enc4b5b = 5'h14;
			4'h3: enc4b5b = 5'h15;
			4'h4: enc4b5b = 5'h0A;
			4'h5: enc4b5b = 5'h0B;
			4'h6: enc4b5b = 5'h0E;
			4'h7: enc4b5b = 5'h0F;
			4'h8: enc4b5b = 5'h12;
			4'h9: enc4b5b = 5'h13;
			4'hA: enc4b5b = 5'h16;
			4'hB: enc4b5b = 5'h17;
			4'hC: enc4b5b = 5'h1A;
			4'hD: enc4b5b = 5'h1B;
			4'hE: enc4b5b = 5'h1C;
			default: enc4b5b = 5'h1D;
		endcase
	endfunction : enc4b5b

	function automatic logic [4:0] dec4b5b(input logic [4:0] s);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 0; i < 16; i++) begin
			if (enc4b5b(4'(i)) == s)
				r = {1'b0, 4'(i)};
		end
		dec4b5b = r;
	endfunction : dec4b5b

	// one code bit per clock here, a 5-bit group every fifth clock
	// the analog serialiser puts these on the line at 125 Mb/s
	fepc_pkg::fepc_tx_state_t tx_state;
	logic [4:0] tx_sym;
	logic [2:0] bit_idx;
	logic sym_done;
	assign sym_done = bit_idx == 3'(`FEPC_BITS_PER_CLK - 1);
	logic [6:0] fef_cnt;
	assign mii_tx_ready = sym_done && !pd;

	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd)
			bit_idx <= 3'h0;
		else
			bit_idx <= sym_done ? 3'h0 : bit_idx + 3'h1;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd) begin
			tx_state <= fepc_pkg::FEPC_TX_IDLE;
			tx_sym <= `FEPC_SYM_IDLE;
		end else if (sym_done) begin
			case (tx_state)
				fepc_pkg::FEPC_TX_IDLE: begin
					if (mii_tx_en) begin
						tx_state <= fepc_pkg::FEPC_TX_J;
						tx_sym <= `FEPC_SYM_J;
					end else
						tx_sym <= `FEPC_SYM_IDLE;
				end
				fepc_pkg::FEPC_TX_J: begin
					tx_state <= fepc_pkg::FEPC_TX_K;
					tx_sym <= `FEPC_SYM_K;
				end
				fepc_pkg::FEPC_TX_K, fepc_pkg::FEPC_TX_DATA: begin
					if (mii_tx_en) begin
						tx_state <= fepc_pkg::FEPC_TX_DATA;
						tx_sym <= enc4b5b(mii_txd);
					end else begin
						tx_state <= fepc_pkg::FEPC_TX_T;
						tx_sym <= `FEPC_SYM_T;
					end
				end
				fepc_pkg::FEPC_TX_T: begin
					tx_state <= fepc_pkg::FEPC_TX_R;
					tx_sym <= `FEPC_SYM_R;
				end
				fepc_pkg::FEPC_TX_R: begin
					tx_state <= fepc_pkg::FEPC_TX_IDLE;
					tx_sym <= `FEPC_SYM_IDLE;
				end
				default: tx_state <= fepc_pkg::FEPC_TX_IDLE;
			endcase
		end
	end

	// fault pattern: 84 ones then a zero, only in idle gaps
	logic tx_idle_gap;
	assign tx_idle_gap = tx_state == fepc_pkg::FEPC_TX_IDLE;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd || !fef_local || !tx_idle_gap)
			fef_cnt <= 7'h00;
		else
			fef_cnt <= (fef_cnt == `FEPC_FEF_ONES) ? 7'h00 : fef_cnt + 7'h01;
	end
	logic code_bit;
	always_comb begin
		if (fef_local && tx_idle_gap)
			code_bit = fef_cnt != `FEPC_FEF_ONES;
		else
			code_bit = tx_sym[3'(4) - bit_idx];
	end

	logic scr_bit;
	logic [10:0] tx_lfsr;
	fepc_scrambler u_tx_scr (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.adv(!pd),
		.load(1'b0),
		.load_val(11'h000),
		.bypass(fx),
		.din(code_bit),
		.dout(scr_bit),
		.state(tx_lfsr)
	);

	// nrzi then mlt3 (fx drives nrzi straight to the optics)
	logic [1:0] mlt_phase;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd) begin
			line_tx_nrzi <= 1'b0;
			mlt_phase <= 2'h0;
		end else if (scr_bit) begin
			line_tx_nrzi <= !line_tx_nrzi;
			mlt_phase <= mlt_phase + 2'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd)
			line_tx_mlt3 <= 2'b00;
		else if (fx)
			line_tx_mlt3 <= {1'b0, line_tx_nrzi};
		else
			case (mlt_phase) // 00 zero, 01 plus, 11 minus
				2'h1: line_tx_mlt3 <= 2'b01;
				2'h3: line_tx_mlt3 <= 2'b11;
				default: line_tx_mlt3 <= 2'b00;
			endcase
	end

	// receive: mlt3 to nrzi (any nonzero level is a one), then nrzi edges to nrz
	logic rx_nrzi;
	logic rx_nrzi_q;
	logic rx_nrz;
	assign rx_nrzi = fx ? line_rx_mlt3[0] : (line_rx_mlt3 != 2'b00);
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			rx_nrzi_q <= 1'b0;
		else
			rx_nrzi_q <= rx_nrzi;
	end
	// transition marks a one; the line is sampled once every clock, with no recovered bit clock
	assign rx_nrz = rx_nrzi ^ rx_nrzi_q;

	// descrambler: lock by loading the ones of an idle stream
	logic [10:0] rx_hist;
	logic [5:0] idle_run;
	logic descr_bit;
	logic [10:0] rx_lfsr;
	logic do_lock;
	assign do_lock = !rx_locked && !fx && idle_run == `FEPC_LOCK_IDLES;
	fepc_scrambler u_rx_scr (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.adv(!pd),
		.load(do_lock),
		.load_val({rx_hist[9:0], ~rx_nrz}), // include this cycle's bit: state for next cycle
		.bypass(fx),
		.din(rx_nrz),
		.dout(descr_bit),
		.state(rx_lfsr)
	);
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd)
			rx_hist <= 11'h000;
		else
			rx_hist <= {rx_hist[9:0], ~rx_nrz}; // idle is all ones in clear
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd || !line_rx_active)
			idle_run <= 6'h00;
		else if (rx_locked && !descr_bit)
			idle_run <= 6'h00;
		else if (idle_run != `FEPC_LOCK_IDLES)
			idle_run <= idle_run + 6'h01;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd || !line_rx_active)
			rx_locked <= 1'b0;
		else if (fx || do_lock)
			rx_locked <= 1'b1;
	end

	// deserialise into symbols and detect incoming fault pattern
	logic [4:0] rx_shift;
	logic [2:0] rx_cnt;
	logic in_frame;
	logic [6:0] ones_run;
	logic [4:0] rx_dec;
	assign rx_dec = dec4b5b(rx_shift);
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd || !rx_locked) begin
			rx_shift <= 5'h00;
			rx_cnt <= 3'h0;
		end else begin
			rx_shift <= {rx_shift[3:0], descr_bit};
			rx_cnt <= (rx_cnt == 3'(`FEPC_BITS_PER_CLK - 1) || ({rx_shift[3:0], descr_bit}
				== `FEPC_SYM_J && !in_frame)) ? 3'h0 : rx_cnt + 3'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd || !rx_locked) begin
			in_frame <= 1'b0;
			mii_rx_dv <= 1'b0;
			mii_rxd <= 4'h0;
		end else if (rx_cnt == 3'h4) begin
			if (rx_shift == `FEPC_SYM_K)
				in_frame <= 1'b1;
			else if (rx_shift == `FEPC_SYM_T || rx_dec == 5'h10)
				in_frame <= 1'b0;
			mii_rx_dv <= in_frame && !rx_dec[4];
			mii_rxd <= rx_dec[3:0];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !fx || !fef_en || pd)
			ones_run <= 7'h00;
		else if (rx_nrz)
			ones_run <= (ones_run == `FEPC_FEF_ONES) ? ones_run : ones_run + 7'h01;
		else
			ones_run <= 7'h00;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !fx || !fef_en || pd)
			fef_rx <= 1'b0;
		else if (ones_run == `FEPC_FEF_ONES && !rx_nrz)
			fef_rx <= 1'b1;
		else if (in_frame)
			fef_rx <= 1'b0;
	end
	assign far_end_fault = fef_local;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd)
			link_up <= 1'b0;
		else
			link_up <= rx_locked && !fef_rx && sd_mode != fepc_pkg::FEPC_SD_FX_FAULT;
	end

	// auto crossover: hunt until the remote is seen on the receive pair
	logic [7:0] xo_timer;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd || fx)
			xo_timer <= 8'h00;
		else
			xo_timer <= (xo_timer == `FEPC_XO_PERIOD) ? 8'h00 : xo_timer + 8'h01;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			mdix <= 1'b0;
		else if (fx)
			mdix <= 1'b0;
		else if (ctrl[`FEPC_CTRL_XO_DIS])
			mdix <= ctrl[`FEPC_CTRL_FORCE_MDIX];
		else if (!line_rx_active && xo_timer == `FEPC_XO_PERIOD)
			mdix <= remote_on_pins12 ? 1'b1 : 1'b0;
	end
	assign pins12_is_tx = !mdix;

	// 10base-t: manchester half-bit clock toggling except in reset and power down; data gated by squelch
	logic clk10;
	logic manch_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd)
			clk10 <= 1'b0;
		else
			clk10 <= !clk10;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || pd || !squelch_ok)
			manch_q <= 1'b0;
		else if (clk10)
			manch_q <= manch_in;
	end
	assign mii_rx_clk10 = clk10 ^ (manch_q & 1'b0);
endmodule : fepc_core
`default_nettype wire

// ### dv/fepc_core_asserts.sv
// port checks for the coding path core
`default_nettype none
module fepc_core_asserts (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic mii_tx_ready,
	input wire logic [1:0] line_tx_mlt3,
	input wire logic [1:0] fiber_signal_detect_in,
	input wire logic pins12_is_tx,
	input wire logic link_up,
	input wire logic far_end_fault,
	input wire logic port_powered
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [1:0] sd = fiber_signal_detect_in;
	// control copy kept from the write strobes, since only ports are visible
	logic [7:0] ctrl;
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			ctrl <= 8'h00;
		else if (reg_wr && reg_addr == 4'h0)
			ctrl <= reg_wdata;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence rd_ctrl_s;
		reg_rd && reg_addr == 4'h0;
	endsequence
	sequence rd_hole_s;
		reg_rd && reg_addr > 4'h1;
	endsequence
	ctrl_read_a: assert property (rd_ctrl_s |=> reg_rdata == ctrl)
		else $error("control readback differs");
	hole_read_a: assert property (rd_hole_s |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_quiet_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	fault_out_a: assert property (port_powered |-> far_end_fault == (sd == 2'b01 && !ctrl[3]))
		else $error("local fault flag wrong");
	power_state_a: assert property (port_powered == !(|ctrl[2:0]))
		else $error("power state wrong");
	ready_gap_a: assert property (disable iff (!rst_b || !port_powered)
		mii_tx_ready |=> !mii_tx_ready [*4] ##1 mii_tx_ready)
		else $error("nibble slot spacing wrong");
	mdix_force_a: assert property (port_powered && sd == 2'b00 && ctrl[5:4] == 2'b11
		&& $stable(ctrl) |-> !pins12_is_tx)
		else $error("forced crossed pairs not applied");
	xo_hold_a: assert property (ctrl[5:4] == 2'b01 && $past(ctrl[5:4]) == 2'b01
		|-> $stable(pins12_is_tx))
		else $error("pairs moved with crossover off");
	fx_no_swap_a: assert property (sd != 2'b00 && $past(sd) != 2'b00 && $past(sd, 2) != 2'b00
		|-> $stable(pins12_is_tx))
		else $error("pairs moved in fiber mode");
	mlt3_level_a: assert property (line_tx_mlt3 != 2'b10)
		else $error("illegal line level");
	reset_state_a: assert property (disable iff (1'b0)
		!rst_b |=> pins12_is_tx && port_powered && !link_up)
		else $error("reset state wrong");
endmodule : fepc_core_asserts
bind fepc_core fepc_core_asserts u_fepc_core_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .mii_tx_ready(mii_tx_ready), .line_tx_mlt3(line_tx_mlt3),
	.fiber_signal_detect_in(fiber_signal_detect_in), .pins12_is_tx(pins12_is_tx),
	.link_up(link_up), .far_end_fault(far_end_fault), .port_powered(port_powered));
`default_nettype wire

// ### dv/fepc_partner.sv
// far end model: fiber idle or fault stream, cable pair sense
`default_nettype none
module fepc_partner (
	input wire logic clk_sys,
	input wire logic send_fef,
	input wire logic tx_on12,
	input wire logic dut_tx12,
	output logic [1:0] line_rx_mlt3,
	output logic line_rx_active,
	output logic squelch_ok,
	output logic manch_in,
	output logic remote_on_pins12
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] cnt = 7'h00;
	logic nrzi = 1'b0;
	always @(posedge clk_sys) begin
		cnt <= (cnt == 7'h54) ? 7'h00 : cnt + 7'h01;
		// idle ones toggle the line, unscrambled in fiber mode
		if (!send_fef || cnt != 7'h54)
			nrzi <= !nrzi;
	end
	assign line_rx_mlt3 = {1'b0, nrzi};
	// energy reaches the local receive pair only when the pair roles line up
	assign line_rx_active = tx_on12 ^ dut_tx12;
	assign squelch_ok = 1'b1;
	assign manch_in = cnt[0];
	assign remote_on_pins12 = tx_on12;
endmodule : fepc_partner
`default_nettype wire

// ### dv/fepc_core_tb_top.sv
// bench for the coding path: registers, crossover, fiber fault
`default_nettype none
module fepc_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst_b, reg_wr, reg_rd, mii_tx_en, send_fef, tx_on12, rx_act, sq_ok, manch;
	logic rem12, tx_rdy, rx_dv, clk10, tx_nrzi, pins12, link_up, fef, pwr;
	logic [3:0] reg_addr, mii_txd, mii_rxd;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [1:0] sd, rx_mlt3, tx_mlt3;
	logic q;
	logic [14:0] sym;
	int miscompares = 0;
	int total_checks = 0;
	int k;
	// address, write data, expected readback, expected powered
	logic [20:0] rows [6] = '{{4'h0, 8'h18, 8'h18, 1'b1}, {4'h0, 8'h02, 8'h02, 1'b0},
		{4'h0, 8'h01, 8'h01, 1'b0}, {4'h0, 8'h3B, 8'h3B, 1'b0},
		{4'h9, 8'hFF, 8'h00, 1'b0}, {4'h0, 8'h00, 8'h00, 1'b1}};
	fepc_core u_fepc_core (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_ready(tx_rdy), .mii_rxd(mii_rxd),
		.mii_rx_dv(rx_dv), .mii_rx_clk10(clk10), .fiber_signal_detect_in(sd),
		.line_rx_mlt3(rx_mlt3), .line_rx_active(rx_act), .squelch_ok(sq_ok), .manch_in(manch),
		.remote_on_pins12(rem12), .line_tx_mlt3(tx_mlt3), .line_tx_nrzi(tx_nrzi),
		.pins12_is_tx(pins12), .link_up(link_up), .far_end_fault(fef), .port_powered(pwr));
	fepc_partner u_fepc_partner (.clk_sys(clk_sys), .send_fef(send_fef), .tx_on12(tx_on12),
		.dut_tx12(pins12),
		.line_rx_mlt3(rx_mlt3), .line_rx_active(rx_act), .squelch_ok(sq_ok),
		.manch_in(manch), .remote_on_pins12(rem12));
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task wait_pins(input logic v);
		for (k = 0; k < 1000 && pins12 !== v; k++)
			@(posedge clk_sys);
	endtask : wait_pins
	// toggles between two held bits; ff when the line never holds
	task ones_run();
		logic p;
		logic st;
		d = 8'h00;
		st = 1'b0;
		@(posedge clk_sys);
		#1 p = tx_nrzi;
		for (int i = 0; i < 400; i++) begin
			@(posedge clk_sys);
			#1;
			if (tx_nrzi === p) begin
				if (st)
					break;
				st = 1'b1;
			end else if (st)
				d++;
			p = tx_nrzi;
		end
		if (!st)
			d = 8'hFF;
	endtask : ones_run
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#(40 * 30000);
		miscompares++;
		finish_test();
	end
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		mii_txd = 4'h5;
		mii_tx_en = 1'b0;
		sd = 2'b00;
		send_fef = 1'b0;
		tx_on12 = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(4'h0);
		chk("ctrl_reset", d, 8'h00);
		for (k = 0; k < 6; k++) begin
			wr(rows[k][20:17], rows[k][16:9]);
			rd(rows[k][20:17]);
			chk("reg_read", d, rows[k][8:1]);
			chk("powered", pwr, rows[k][0]);
		end
		tx_on12 <= 1'b1;
		wait_pins(1'b0);
		chk("xo_swap", pins12, 1'b0);
		tx_on12 <= 1'b0;
		wait_pins(1'b1);
		chk("xo_back", pins12, 1'b1);
		wr(4'h0, 8'h10);
		tx_on12 <= 1'b1;
		repeat (600) @(posedge clk_sys);
		chk("xo_off", pins12, 1'b1);
		wr(4'h0, 8'h30);
		repeat (2) @(posedge clk_sys);
		chk("mdix_forced", pins12, 1'b0);
		d = 8'h00;
		repeat (40) begin
			@(posedge clk_sys);
			#1 d = d + {7'h00, clk10};
		end
		chk("rx_clk10_runs", {7'h00, d > 8'h00 && d < 8'h28}, 8'h01);
		wr(4'h0, 8'h00);
		sd <= 2'b01;
		tx_on12 <= 1'b0;
		ones_run();
		chk("fef_pattern", d, 8'h54);
		chk("fef_flag", fef, 1'b1);
		wr(4'h0, 8'h08);
		ones_run();
		chk("fef_disabled", d, 8'hFF);
		wr(4'h0, 8'h00);
		sd <= 2'b11;
		ones_run();
		chk("fx_idle", d, 8'hFF);
		send_fef <= 1'b1;
		repeat (600) @(posedge clk_sys);
		rd(4'h1);
		chk("rx_fef_stat", d & 8'h18, 8'h18);
		chk("link_down", link_up, 1'b0);
		ones_run();
		chk("tx_unchanged", d, 8'hFF);
		@(posedge clk_sys);
		mii_tx_en <= 1'b1;
		do begin
			@(posedge clk_sys);
			#1;
		end while (tx_rdy !== 1'b1);
		@(posedge clk_sys);
		#1 q = tx_nrzi;
		repeat (15) begin
			@(posedge clk_sys);
			#1 sym = {sym[13:0], tx_nrzi !== q};
			q = tx_nrzi;
		end
		chk("frame_j", {3'h0, sym[14:10]}, 8'h18);
		chk("frame_k", {3'h0, sym[9:5]}, 8'h11);
		chk("frame_data", {3'h0, sym[4:0]}, 8'h0B);
		@(posedge clk_sys);
		mii_tx_en <= 1'b0;
		#1 chk("fx_mlt3", {7'h00, tx_mlt3[1]}, 8'h00);
		chk("rx_dv_idle", {7'h00, rx_dv}, 8'h00);
		wr(4'h0, 8'h04);
		@(posedge clk_sys);
		#1 chk("chip_down", pwr, 1'b0);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1 chk("chip_up", pwr, 1'b1);
		finish_test();
	end
endmodule : fepc_core_tb_top
`default_nettype wire
